/* File: core_model.sv */
// Behavioural core that issues port instructions and posts vectors
`timescale 1ns/10ps
`default_nettype none
module core_model (
    input  wire logic                 ref_clk_i,   // CPU clock
    input  wire io_port_pkg::io_rsp_t rsp_i,       // Block answer
    output io_port_pkg::io_req_t      req_o,       // Instruction
    output logic                      vec_set_o,   // Vector post pulse
    output logic      [7:0]           vec_value_o  // Vector value
);
    initial begin
        req_o = '0;
        vec_set_o = 1'b0;
        vec_value_o = 8'h00;
    end
    // Caller stands just past an edge; request held over its taking edge
    task automatic exec(input io_port_pkg::io_op_t op, input logic [7:0] a,
                        input logic [7:0] x, input logic [7:0] d,
                        output io_port_pkg::io_rsp_t r);
        req_o = '{op: op, addr: a, index: x, acc: d};
        @(posedge ref_clk_i);
        #1;
        r = rsp_i;
    endtask
    // Released fields do not keep their last value
    task automatic idle();
        req_o = '{op: io_port_pkg::OP_NONE, addr: ~req_o.addr,
                  index: ~req_o.index, acc: ~req_o.acc};
    endtask
    task automatic post(input logic [7:0] v);
        vec_set_o = 1'b1;
        vec_value_o = v;
        @(posedge ref_clk_i);
        #1;
        vec_set_o = 1'b0;
        vec_value_o = ~v;
    endtask
endmodule
`default_nettype wire

/* File: io_addr_former.sv */
// Effective I/O address formation for direct and indexed instructions
`timescale 1ns/10ps
`default_nettype none
module io_addr_former (
    input  wire logic                  is_indexed_i,  // Indexed write form
    input  wire logic [7:0]            addr_i,        // Instruction address field
    input  wire logic [7:0]            index_i,       // Index register
    output logic      [7:0]            eff_addr_o     // Resulting address
);
    wire logic [7:0] indexed_sum;
    wire logic       zero_field;

    // Wraps within 8 bits
    assign indexed_sum = 8'(addr_i + index_i);
    assign zero_field  = (addr_i == io_port_pkg::ZERO_ADDR);
    assign eff_addr_o  = !is_indexed_i ? addr_i :
                         zero_field    ? index_i :
                                         indexed_sum;
endmodule
`default_nettype wire

/* File: io_port_pkg.sv */
// Shared constants and carrier types for the I/O register space
package io_port_pkg;

    localparam int unsigned DATA_W = 8;
    localparam int unsigned ADDR_W = 8;

    localparam logic [7:0] OFS_GPIO_PORT0_DATA           = 8'h00;
    localparam logic [7:0] OFS_GPIO_PORT1_DATA           = 8'h01;
    localparam logic [7:0] OFS_GPIO_PORT2_DATA           = 8'h02;
    localparam logic [7:0] OFS_GPIO_PORT3_DATA           = 8'h03;
    localparam logic [7:0] OFS_PORT0_PIN_IRQ_ENABLE      = 8'h04;
    localparam logic [7:0] OFS_PORT1_PIN_IRQ_ENABLE      = 8'h05;
    localparam logic [7:0] OFS_PORT2_PIN_IRQ_ENABLE      = 8'h06;
    localparam logic [7:0] OFS_PORT3_PIN_IRQ_ENABLE      = 8'h07;
    localparam logic [7:0] OFS_PIN_PORT_CONFIGURATION    = 8'h08;
    localparam logic [7:0] OFS_PARALLEL_WIDTH_TWOWIRE    = 8'h09;
    localparam logic [7:0] OFS_USB_FUNCTION_ADDRESS_A    = 8'h10;
    localparam logic [7:0] OFS_ADDR_A_EP0_BYTE_COUNT     = 8'h11;
    localparam logic [7:0] OFS_ADDR_A_EP0_CONFIG         = 8'h12;
    localparam logic [7:0] OFS_ADDR_A_EP1_BYTE_COUNT     = 8'h13;
    localparam logic [7:0] OFS_ADDR_A_EP1_CONFIG         = 8'h14;
    localparam logic [7:0] OFS_ADDR_A_EP2_BYTE_COUNT     = 8'h15;
    localparam logic [7:0] OFS_ADDR_A_EP2_CONFIG         = 8'h16;
    localparam logic [7:0] OFS_GLOBAL_IRQ_ENABLES        = 8'h20;
    localparam logic [7:0] OFS_USB_ENDPOINT_IRQ_ENABLES  = 8'h21;
    localparam logic [7:0] OFS_PENDING_IRQ_VECTOR        = 8'h23;

    localparam logic [7:0] ZERO_ADDR                     = 8'h00;
    localparam logic [7:0] RESET_VALUE                   = 8'h00;
    localparam logic [7:0] UNMAPPED_READ                 = 8'h00;
    localparam logic [7:0] WRITE_ONLY_READ               = 8'h00;

    typedef enum logic [1:0] {
        OP_NONE,
        OP_PORT_READ,
        OP_PORT_WRITE,
        OP_INDEXED_PORT_WRITE
    } io_op_t;

    // One instruction from the core
    typedef struct packed {
        io_op_t      op;
        logic [7:0]  addr;
        logic [7:0]  index;
        logic [7:0]  acc;
    } io_req_t;

    // Answer of the block, registered
    typedef struct packed {
        logic        rd_valid;
        logic [7:0]  rd_data;
        logic        wr_done;
        logic [7:0]  wr_addr;
    } io_rsp_t;

endpackage

/* File: io_port_register_decode.sv */
// I/O register space decode, storage and read-to-clear vector
`timescale 1ns/10ps
`default_nettype none

// Behaviour
// - Port read returns addressed register contents toward the accumulator.
// - Direct port write stores accumulator into register at instruction address.
// - Indexed write targets instruction address plus index register.
// - Indexed write with zero address field uses the index register alone.
// - Undefined addresses are reserved; writes there are dropped.
// - Pin interrupt enables at 0x04..0x07 are write-only, read as zero.
// - Reading the vector register returns pending vector and clears it.
module io_port_register_decode #(
    parameter int unsigned DATA_WIDTH = 8
) (
    input  wire logic                  ref_clk_i,     // CPU clock, 25 MHz
    input  wire logic                  arst_n_i,      // Async reset, active low
    input  wire io_port_pkg::io_req_t  req_i,         // Instruction from core
    input  wire logic                  vec_set_i,     // Pending vector load pulse
    input  wire logic [7:0]            vec_value_i,   // Vector to post
    output io_port_pkg::io_rsp_t       rsp_o,         // Registered answer
    output logic      [7:0]            port_data_o [4], // Port data registers
    output logic      [7:0]            pin_irq_en_o [4], // Pin irq enables
    output logic      [7:0]            port_cfg_o,    // Pin configuration
    output logic      [7:0]            par_tw_cfg_o,  // Parallel/two-wire cfg
    output logic      [7:0]            usb_addr_a_o,  // USB address A
    output logic      [7:0]            ep_count_o [3], // Endpoint counters
    output logic      [7:0]            ep_cfg_o [3],  // Endpoint configs
    output logic      [7:0]            global_irq_en_o, // Global irq enables
    output logic      [7:0]            ep_irq_en_o,   // Endpoint irq enables
    output logic                       vec_pending_o  // Vector pending flag
);
    localparam int unsigned NREG = 19;

    // Only byte-wide registers are supported
    if (DATA_WIDTH != io_port_pkg::DATA_W) begin : g_bad_width
        $error("DATA_WIDTH must be 8");
    end

    // Storable register offsets, indexed 0..NREG-1
    localparam logic [7:0] REG_OFS [NREG] = '{
        io_port_pkg::OFS_GPIO_PORT0_DATA,
        io_port_pkg::OFS_GPIO_PORT1_DATA,
        io_port_pkg::OFS_GPIO_PORT2_DATA,
        io_port_pkg::OFS_GPIO_PORT3_DATA,
        io_port_pkg::OFS_PORT0_PIN_IRQ_ENABLE,
        io_port_pkg::OFS_PORT1_PIN_IRQ_ENABLE,
        io_port_pkg::OFS_PORT2_PIN_IRQ_ENABLE,
        io_port_pkg::OFS_PORT3_PIN_IRQ_ENABLE,
        io_port_pkg::OFS_PIN_PORT_CONFIGURATION,
        io_port_pkg::OFS_PARALLEL_WIDTH_TWOWIRE,
        io_port_pkg::OFS_USB_FUNCTION_ADDRESS_A,
        io_port_pkg::OFS_ADDR_A_EP0_BYTE_COUNT,
        io_port_pkg::OFS_ADDR_A_EP0_CONFIG,
        io_port_pkg::OFS_ADDR_A_EP1_BYTE_COUNT,
        io_port_pkg::OFS_ADDR_A_EP1_CONFIG,
        io_port_pkg::OFS_ADDR_A_EP2_BYTE_COUNT,
        io_port_pkg::OFS_ADDR_A_EP2_CONFIG,
        io_port_pkg::OFS_GLOBAL_IRQ_ENABLES,
        io_port_pkg::OFS_USB_ENDPOINT_IRQ_ENABLES
    };
    // Write-only flags per entry
    localparam logic [NREG-1:0] REG_WO = 19'h0_00F0;

    wire logic        is_read;
    wire logic        is_write;
    wire logic        is_indexed;
    wire logic [7:0]  eff_addr;
    wire logic [NREG-1:0] hit;
    wire logic [NREG-1:0] we;
    wire logic        vec_hit;
    wire logic        vec_read;
    wire logic [7:0]  reg_q [NREG];
    logic      [7:0]  rd_mux;

    logic      [7:0]  vec_reg;
    logic             vec_flag;
    wire logic [7:0]  next_vec_reg;
    wire logic        next_vec_flag;

    assign is_read    = (req_i.op == io_port_pkg::OP_PORT_READ);
    assign is_indexed = (req_i.op == io_port_pkg::OP_INDEXED_PORT_WRITE);
    assign is_write   = (req_i.op == io_port_pkg::OP_PORT_WRITE) || is_indexed;

    io_addr_former u_addr (
        .is_indexed_i (is_indexed),
        .addr_i       (req_i.addr),
        .index_i      (req_i.index),
        .eff_addr_o   (eff_addr)
    );

    genvar g;
    generate
        for (g = 0; g < NREG; g++) begin : g_reg
            assign hit[g] = (eff_addr == REG_OFS[g]);
            // Unmapped addresses match no entry, so no write happens
            assign we[g]  = is_write && hit[g];
            io_reg_cell #(.WIDTH(8)) u_cell (
                .ref_clk_i (ref_clk_i),
                .arst_n_i  (arst_n_i),
                .we_i      (we[g]),
                .wdata_i   (req_i.acc),
                .q_o       (reg_q[g])
            );
        end
    endgenerate

    assign vec_hit  = (eff_addr == io_port_pkg::OFS_PENDING_IRQ_VECTOR);
    assign vec_read = is_read && vec_hit;

    // Read mux, write-only and unmapped read as zero
    always_comb begin
        rd_mux = io_port_pkg::UNMAPPED_READ;
        for (int i = 0; i < NREG; i++) begin
            if (hit[i]) begin
                rd_mux = REG_WO[i] ? io_port_pkg::WRITE_ONLY_READ : reg_q[i];
            end
        end
        if (vec_hit) begin
            rd_mux = vec_reg;
        end
    end

    // Posting wins over the clear of the read
    assign next_vec_flag = vec_set_i ? 1'b1 : (vec_read ? 1'b0 : vec_flag);
    assign next_vec_reg  = vec_set_i ? vec_value_i :
                           (vec_read ? io_port_pkg::RESET_VALUE : vec_reg);

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            vec_reg  <= io_port_pkg::RESET_VALUE;
            vec_flag <= 1'b0;
        end else begin
            vec_reg  <= next_vec_reg;
            vec_flag <= next_vec_flag;
        end
    end

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rsp_o <= '0;
        end else begin
            rsp_o.rd_valid <= is_read;
            rsp_o.rd_data  <= is_read ? rd_mux : io_port_pkg::RESET_VALUE;
            rsp_o.wr_done  <= is_write;
            rsp_o.wr_addr  <= is_write ? eff_addr : io_port_pkg::ZERO_ADDR;
        end
    end

    generate
        for (g = 0; g < 4; g++) begin : g_port
            assign port_data_o[g]  = reg_q[g];
            assign pin_irq_en_o[g] = reg_q[4+g];
        end
        for (g = 0; g < 3; g++) begin : g_ep
            assign ep_count_o[g] = reg_q[11+2*g];
            assign ep_cfg_o[g]   = reg_q[12+2*g];
        end
    endgenerate
    assign port_cfg_o      = reg_q[8];
    assign par_tw_cfg_o    = reg_q[9];
    assign usb_addr_a_o    = reg_q[10];
    assign global_irq_en_o = reg_q[17];
    assign ep_irq_en_o     = reg_q[18];
    assign vec_pending_o   = vec_flag;

    a_read_returns_data: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        is_read && req_i.addr == io_port_pkg::OFS_USB_FUNCTION_ADDRESS_A
        |=> rsp_o.rd_valid && rsp_o.rd_data == $past(usb_addr_a_o))
        else $error("read data mismatch");
    a_direct_write_stores: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        req_i.op == io_port_pkg::OP_PORT_WRITE && req_i.addr == 8'h00
        |=> port_data_o[0] == $past(req_i.acc))
        else $error("direct write lost");
    a_indexed_sum_addr: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        is_indexed && req_i.addr != 8'h00
        |=> rsp_o.wr_addr == 8'($past(req_i.addr) + $past(req_i.index)))
        else $error("indexed address wrong");
    a_indexed_zero_field: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        is_indexed && req_i.addr == 8'h00 |=> rsp_o.wr_addr == $past(req_i.index))
        else $error("zero-field index wrong");
    a_unmapped_no_write: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        is_write && hit == '0 |=> $stable(usb_addr_a_o) && $stable(port_cfg_o))
        else $error("reserved write changed state");
    a_wo_reads_zero: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        is_read && eff_addr >= 8'h04 && eff_addr <= 8'h07 |=> rsp_o.rd_data == 8'h00)
        else $error("write-only read nonzero");
    a_vector_read_clear: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        vec_read && !vec_set_i |=> rsp_o.rd_data == $past(vec_reg) && !vec_pending_o)
        else $error("vector not cleared");
    a_vector_set_wins: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        vec_set_i |=> vec_pending_o && vec_reg == $past(vec_value_i))
        else $error("vector post lost");
    a_no_rsp_idle: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        req_i.op == io_port_pkg::OP_NONE |=> !rsp_o.rd_valid && !rsp_o.wr_done)
        else $error("spurious answer");

    // Shared shapes for the per-register checks
    property p_write_lands(logic sel, logic [7:0] q);
        @(posedge ref_clk_i) disable iff (!arst_n_i)
        is_write && sel |=> q == $past(req_i.acc);
    endproperty
    property p_read_back(logic sel, logic [7:0] q);
        @(posedge ref_clk_i) disable iff (!arst_n_i)
        is_read && sel |=> rsp_o.rd_valid && rsp_o.rd_data == $past(q);
    endproperty

    a_port1_write_lands: assert property (
        p_write_lands(eff_addr == io_port_pkg::OFS_GPIO_PORT1_DATA,
                      port_data_o[1]))
        else $error("port 1 write lost");
    a_port2_write_lands: assert property (
        p_write_lands(eff_addr == io_port_pkg::OFS_GPIO_PORT2_DATA,
                      port_data_o[2]))
        else $error("port 2 write lost");
    a_port3_write_lands: assert property (
        p_write_lands(eff_addr == io_port_pkg::OFS_GPIO_PORT3_DATA,
                      port_data_o[3]))
        else $error("port 3 write lost");
    a_irqen0_write_lands: assert property (
        p_write_lands(eff_addr == io_port_pkg::OFS_PORT0_PIN_IRQ_ENABLE,
                      pin_irq_en_o[0]))
        else $error("pin enable 0 write lost");
    a_irqen1_write_lands: assert property (
        p_write_lands(eff_addr == io_port_pkg::OFS_PORT1_PIN_IRQ_ENABLE,
                      pin_irq_en_o[1]))
        else $error("pin enable 1 write lost");
    a_irqen2_write_lands: assert property (
        p_write_lands(eff_addr == io_port_pkg::OFS_PORT2_PIN_IRQ_ENABLE,
                      pin_irq_en_o[2]))
        else $error("pin enable 2 write lost");
    a_irqen3_write_lands: assert property (
        p_write_lands(eff_addr == io_port_pkg::OFS_PORT3_PIN_IRQ_ENABLE,
                      pin_irq_en_o[3]))
        else $error("pin enable 3 write lost");
    a_cfg_write_lands: assert property (
        p_write_lands(eff_addr == io_port_pkg::OFS_PIN_PORT_CONFIGURATION,
                      port_cfg_o))
        else $error("pin config write lost");
    a_partw_write_lands: assert property (
        p_write_lands(eff_addr == io_port_pkg::OFS_PARALLEL_WIDTH_TWOWIRE,
                      par_tw_cfg_o))
        else $error("parallel config write lost");
    a_usbaddr_write_lands: assert property (
        p_write_lands(eff_addr == io_port_pkg::OFS_USB_FUNCTION_ADDRESS_A,
                      usb_addr_a_o))
        else $error("usb address write lost");
    a_epcnt0_write_lands: assert property (
        p_write_lands(eff_addr == io_port_pkg::OFS_ADDR_A_EP0_BYTE_COUNT,
                      ep_count_o[0]))
        else $error("ep0 count write lost");
    a_epcnt1_write_lands: assert property (
        p_write_lands(eff_addr == io_port_pkg::OFS_ADDR_A_EP1_BYTE_COUNT,
                      ep_count_o[1]))
        else $error("ep1 count write lost");
    a_epcnt2_write_lands: assert property (
        p_write_lands(eff_addr == io_port_pkg::OFS_ADDR_A_EP2_BYTE_COUNT,
                      ep_count_o[2]))
        else $error("ep2 count write lost");
    a_epcfg0_write_lands: assert property (
        p_write_lands(eff_addr == io_port_pkg::OFS_ADDR_A_EP0_CONFIG,
                      ep_cfg_o[0]))
        else $error("ep0 config write lost");
    a_epcfg1_write_lands: assert property (
        p_write_lands(eff_addr == io_port_pkg::OFS_ADDR_A_EP1_CONFIG,
                      ep_cfg_o[1]))
        else $error("ep1 config write lost");
    a_epcfg2_write_lands: assert property (
        p_write_lands(eff_addr == io_port_pkg::OFS_ADDR_A_EP2_CONFIG,
                      ep_cfg_o[2]))
        else $error("ep2 config write lost");
    a_gie_write_lands: assert property (
        p_write_lands(eff_addr == io_port_pkg::OFS_GLOBAL_IRQ_ENABLES,
                      global_irq_en_o))
        else $error("global enable write lost");
    a_epie_write_lands: assert property (
        p_write_lands(eff_addr == io_port_pkg::OFS_USB_ENDPOINT_IRQ_ENABLES,
                      ep_irq_en_o))
        else $error("endpoint enable write lost");

    a_port0_read_back: assert property (
        p_read_back(req_i.addr == io_port_pkg::OFS_GPIO_PORT0_DATA,
                    port_data_o[0]))
        else $error("port 0 read wrong");
    a_port1_read_back: assert property (
        p_read_back(req_i.addr == io_port_pkg::OFS_GPIO_PORT1_DATA,
                    port_data_o[1]))
        else $error("port 1 read wrong");
    a_port2_read_back: assert property (
        p_read_back(req_i.addr == io_port_pkg::OFS_GPIO_PORT2_DATA,
                    port_data_o[2]))
        else $error("port 2 read wrong");
    a_port3_read_back: assert property (
        p_read_back(req_i.addr == io_port_pkg::OFS_GPIO_PORT3_DATA,
                    port_data_o[3]))
        else $error("port 3 read wrong");
    a_cfg_read_back: assert property (
        p_read_back(req_i.addr == io_port_pkg::OFS_PIN_PORT_CONFIGURATION,
                    port_cfg_o))
        else $error("pin config read wrong");
    a_partw_read_back: assert property (
        p_read_back(req_i.addr == io_port_pkg::OFS_PARALLEL_WIDTH_TWOWIRE,
                    par_tw_cfg_o))
        else $error("parallel config read wrong");
    a_epcnt0_read_back: assert property (
        p_read_back(req_i.addr == io_port_pkg::OFS_ADDR_A_EP0_BYTE_COUNT,
                    ep_count_o[0]))
        else $error("ep0 count read wrong");
    a_epcnt1_read_back: assert property (
        p_read_back(req_i.addr == io_port_pkg::OFS_ADDR_A_EP1_BYTE_COUNT,
                    ep_count_o[1]))
        else $error("ep1 count read wrong");
    a_epcnt2_read_back: assert property (
        p_read_back(req_i.addr == io_port_pkg::OFS_ADDR_A_EP2_BYTE_COUNT,
                    ep_count_o[2]))
        else $error("ep2 count read wrong");
    a_epcfg0_read_back: assert property (
        p_read_back(req_i.addr == io_port_pkg::OFS_ADDR_A_EP0_CONFIG,
                    ep_cfg_o[0]))
        else $error("ep0 config read wrong");
    a_epcfg1_read_back: assert property (
        p_read_back(req_i.addr == io_port_pkg::OFS_ADDR_A_EP1_CONFIG,
                    ep_cfg_o[1]))
        else $error("ep1 config read wrong");
    a_epcfg2_read_back: assert property (
        p_read_back(req_i.addr == io_port_pkg::OFS_ADDR_A_EP2_CONFIG,
                    ep_cfg_o[2]))
        else $error("ep2 config read wrong");
    a_gie_read_back: assert property (
        p_read_back(req_i.addr == io_port_pkg::OFS_GLOBAL_IRQ_ENABLES,
                    global_irq_en_o))
        else $error("global enable read wrong");
    a_epie_read_back: assert property (
        p_read_back(req_i.addr == io_port_pkg::OFS_USB_ENDPOINT_IRQ_ENABLES,
                    ep_irq_en_o))
        else $error("endpoint enable read wrong");

    c_read_vector: cover property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        vec_flag && vec_read);
    c_indexed_zero: cover property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        is_indexed && req_i.addr == 8'h00);
    c_indexed_sum: cover property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        is_indexed && req_i.addr != 8'h00 && |we);
    c_write_then_read: cover property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        is_write && |we ##1 is_read);
    c_write_only_read: cover property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        is_read && req_i.addr == io_port_pkg::OFS_PORT0_PIN_IRQ_ENABLE);
endmodule
`default_nettype wire

/* File: io_port_register_decode_tb.sv */
// Self-checking bench for the I/O register space
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin n_mismatch++; \
    $display("[ERR] %0t got %h expected %h", $time, a, b); end end
module io_port_register_decode_tb;
    logic                 ref_clk;
    logic                 arst_n;
    io_port_pkg::io_req_t req;
    io_port_pkg::io_rsp_t rsp;
    io_port_pkg::io_rsp_t r;
    logic                 vset;
    logic [7:0]           vval;
    logic [7:0]           pd [4];
    logic [7:0]           pie [4];
    logic [7:0]           epc [3];
    logic [7:0]           epm [3];
    logic [7:0]           cfg, ptw, usba, gie, epie;
    logic                 pend;
    logic [7:0]           exp_q [256];
    int                   n_mismatch = 0;
    int                   checked = 0;
    int                   cycles = 0;
    localparam logic [7:0] RW_LIST [15] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h08,
        8'h09, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16, 8'h20, 8'h21};

    core_model core (.ref_clk_i(ref_clk), .rsp_i(rsp), .req_o(req),
                     .vec_set_o(vset), .vec_value_o(vval));
    io_port_register_decode uut (
        .ref_clk_i(ref_clk), .arst_n_i(arst_n), .req_i(req), .vec_set_i(vset),
        .vec_value_i(vval), .rsp_o(rsp), .port_data_o(pd), .pin_irq_en_o(pie),
        .port_cfg_o(cfg), .par_tw_cfg_o(ptw), .usb_addr_a_o(usba),
        .ep_count_o(epc), .ep_cfg_o(epm), .global_irq_en_o(gie),
        .ep_irq_en_o(epie), .vec_pending_o(pend));

    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 4000) begin
            n_mismatch++;
            give_verdict();
        end
    end

    function automatic bit stored(input logic [7:0] a);
        return a inside {[8'h00:8'h09], [8'h10:8'h16], 8'h20, 8'h21};
    endfunction

    task automatic check_all();
        for (int i = 0; i < 4; i++) begin
            `CHK(pd[i], exp_q[i])
            `CHK(pie[i], exp_q[4 + i])
        end
        for (int i = 0; i < 3; i++) begin
            `CHK(epc[i], exp_q[8'h11 + 2 * i])
            `CHK(epm[i], exp_q[8'h12 + 2 * i])
        end
        `CHK({cfg, ptw, usba, gie, epie}, {exp_q[8], exp_q[9], exp_q[16], exp_q[32], exp_q[33]})
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        core.exec(io_port_pkg::OP_PORT_READ, a, 8'h00, 8'h00, r);
        `CHK({r.rd_valid, r.wr_done, r.rd_data}, {2'b10, e})
    endtask

    task automatic wr(input io_port_pkg::io_op_t op, input logic [7:0] a,
                      input logic [7:0] x, input logic [7:0] d, input logic [7:0] eff);
        core.exec(op, a, x, d, r);
        if (stored(eff)) begin
            exp_q[eff] = d;
        end
        `CHK({r.rd_valid, r.wr_done, r.wr_addr}, {2'b01, eff})
        check_all();
    endtask

    task automatic t_direct();
        foreach (RW_LIST[i]) wr(io_port_pkg::OP_PORT_WRITE, RW_LIST[i], 8'h3C,
                                RW_LIST[i] ^ 8'hA5, RW_LIST[i]);
        foreach (RW_LIST[i]) rd(RW_LIST[i], exp_q[RW_LIST[i]]);
    endtask

    task automatic t_write_only();
        for (int i = 4; i < 8; i++) begin
            wr(io_port_pkg::OP_PORT_WRITE, 8'(i), 8'h00, 8'(8'hC0 + i), 8'(i));
            rd(8'(i), io_port_pkg::WRITE_ONLY_READ);
        end
    endtask

    task automatic t_indexed();
        wr(io_port_pkg::OP_INDEXED_PORT_WRITE, 8'h10, 8'h03, 8'h77, 8'h13);
        wr(io_port_pkg::OP_INDEXED_PORT_WRITE, 8'h00, 8'h08, 8'h4E, 8'h08);
        wr(io_port_pkg::OP_INDEXED_PORT_WRITE, 8'hF0, 8'h11, 8'h91, 8'h01);
        rd(8'h13, 8'h77);
    endtask

    task automatic t_reserved();
        // Direct and indexed writes to 0x23 are dropped; reads of 0x0A and 0x2F return zero
        wr(io_port_pkg::OP_PORT_WRITE, 8'h23, 8'h00, 8'hEE, 8'h23);
        wr(io_port_pkg::OP_INDEXED_PORT_WRITE, 8'h1F, 8'h04, 8'hDD, 8'h23);
        rd(8'h0A, io_port_pkg::UNMAPPED_READ);
        rd(8'h2F, io_port_pkg::UNMAPPED_READ);
        check_all();
    endtask

    task automatic t_vector();
        core.idle();
        core.post(8'h5C);
        `CHK(pend, 1'b1)
        rd(8'h23, 8'h5C);
        `CHK(pend, 1'b0)
        rd(8'h23, 8'h00);
    endtask

    initial begin
        arst_n = 1'b0;
        foreach (exp_q[i]) exp_q[i] = io_port_pkg::RESET_VALUE;
        repeat (2) @(posedge ref_clk);
        #1;
        arst_n = 1'b1;
        check_all();
        `CHK(pend, 1'b0)
        foreach (RW_LIST[i]) rd(RW_LIST[i], io_port_pkg::RESET_VALUE);
        t_direct();
        t_write_only();
        t_indexed();
        t_reserved();
        t_vector();
        give_verdict();
    end
endmodule
`default_nettype wire

/* File: io_reg_cell.sv */
// One 8-bit storage register with write strobe
`timescale 1ns/10ps
`default_nettype none
module io_reg_cell #(
    parameter int unsigned WIDTH = 8
) (
    input  wire logic             ref_clk_i,  // CPU clock
    input  wire logic             arst_n_i,   // Async reset, active low
    input  wire logic             we_i,       // Write strobe
    input  wire logic [WIDTH-1:0] wdata_i,    // Write data
    output logic      [WIDTH-1:0] q_o         // Stored value
);
    // Only byte-wide cells are supported
    if (WIDTH != io_port_pkg::DATA_W) begin : g_bad_width
        $error("io_reg_cell width must be 8");
    end

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            q_o <= WIDTH'(io_port_pkg::RESET_VALUE);
        end else if (we_i) begin
            q_o <= wdata_i;
        end
    end
endmodule
`default_nettype wire
